/* File: src/srx_device_end.sv */
// Notes on behaviour
// (R1) maintenance requests go to internal handler
// (R2) handler does register access, sends replies itself
// (R3) memory requests steered to logical port one
// (R4) target turns request into bus master cycle
// (R5) 64 kB test memory, also processor accessible
// (R6) NRead and NWrite_R get a response packet
// (R7) responses tagged 2'b11 go to soft queue
// (R8) software tags its requests 2'b11 in SrcTID
// (R9) soft queue forwards only a fully loaded packet
// (R10) register slave port reaches configuration registers
// (R11) counters for received, transmitted, error packets
// (R12) lane rate fixed by build
// (R13) width negotiated, 1x against single-lane partner
// (R14) requests use 34-bit addresses, top zero
// (R15) only 8-bit device identifiers used
// (R16) unrecognised packets dropped and counted as errors
`default_nettype none
module srx_device_end
   import srx_pkg::*;
#(
   parameter logic [2:0] OWN_LANES = 3'h4,
   parameter int MEM_WORDS = MEM_BYTES / 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // link
   srx_link_if.device lnk,
   // cpu register slave port
   input wire logic i_wbs_cyc,
   input wire logic i_wbs_stb,
   input wire logic i_wbs_we,
   input wire logic [7:0] i_wbs_adr,
   input wire logic [31:0] i_wbs_dat,
   output logic [31:0] o_wbs_dat,
   output logic o_wbs_ack,
   // cpu test memory port
   input wire logic i_mem_req,
   input wire logic i_mem_we,
   input wire logic [MEM_AW-1:0] i_mem_addr,
   input wire logic [31:0] i_mem_wdata,
   output logic [31:0] o_mem_rdata,
   output logic o_mem_ack,
   // soft packet queue, transmit load
   input wire logic i_sq_load,
   input wire srx_pkt_t i_sq_pkt,
   input wire logic i_sq_send,
   output logic o_sq_busy,
   // soft packet queue, receive
   output logic o_sq_rx_valid,
   output srx_pkt_t o_sq_rx_pkt,
   input wire logic i_sq_rx_take,
   // negotiated link width
   output logic [2:0] o_link_width
);
   localparam int WAW = $clog2(MEM_WORDS);

   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_BUS = 2'h1,
      S_SEND = 2'h3
   } srx_state_t;

   srx_state_t state;
   srx_state_t next_state;
   logic [31:0] cfg [CFG_N];
   logic [31:0] mem [MEM_WORDS];
   logic [31:0] rx_cnt;
   logic [31:0] tx_cnt;
   logic [31:0] err_cnt;
   srx_pkt_t req;
   srx_pkt_t rply;
   srx_pkt_t sq_pkt;
   logic sq_armed;
   logic rx_ready;
   srx_pkt_t tx_pkt;
   logic tx_valid;
   logic wb_ack;
   logic [31:0] wb_dat;

   // register read decode, shared by slave port and maintenance handler
   function automatic logic [31:0] reg_read(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      if (a < REG_CFG_END) begin
         v = cfg[a[4:2]];
      end else if (a == REG_RX_CNT) begin
         v = rx_cnt;
      end else if (a == REG_TX_CNT) begin
         v = tx_cnt;
      end else if (a == REG_ERR_CNT) begin
         v = err_cnt;
      end else if (a == REG_LINK) begin
         v = {LANE_RATE_MBPS, 13'h0, o_link_width};
      end
      return v;
   endfunction

   // receive classification
   srx_pkt_t p;
   assign p = lnk.p2d_pkt;
   wire rx_take = lnk.p2d_valid & rx_ready;
   wire is_maint_req = (p.ftype == FT_MAINT) &
      ((p.ttype == TT_MREAD) | (p.ttype == TT_MWRITE));
   wire is_maint_rsp = (p.ftype == FT_MAINT) &
      ((p.ttype == TT_MREAD_RSP) | (p.ttype == TT_MWRITE_RSP));
   wire is_mem_req = (p.ftype == FT_NREAD) | ((p.ftype == FT_WRITE) &
      ((p.ttype == TT_NWRITE) | (p.ttype == TT_NWRITE_R)));
   wire is_rsp = (p.ftype == FT_RESP) | is_maint_rsp;
   wire sq_tagged = p.tid[TID_TAG_HI:TID_TAG_LO] == SQ_TAG;
   // a full receive slot cannot take the answer, so it counts as lost
   wire to_sq = is_rsp & sq_tagged & ~o_sq_rx_valid; // (R7)
   wire in_idle = state == S_IDLE;
   wire do_maint = in_idle & rx_take & is_maint_req; // (R1)
   wire do_mem = in_idle & rx_take & is_mem_req; // (R3)
   wire do_sq_rx = in_idle & rx_take & to_sq;
   wire do_drop = in_idle & rx_take & ~is_maint_req & ~is_mem_req
                  & ~to_sq; // (R16)
   wire maint_wr = do_maint & (p.ttype == TT_MWRITE);
   wire sq_start = in_idle & ~rx_take & sq_armed; // (R9)
   wire tx_free = ~tx_valid | lnk.d2p_ready;
   wire tx_fire = tx_valid & lnk.d2p_ready;
   wire tgt_stb = (state == S_BUS) & ~wb_ack; // (R4)
   wire tgt_we = req.ftype == FT_WRITE;
   wire need_rsp = (req.ftype == FT_NREAD) | (req.ttype == TT_NWRITE_R);
   wire cpu_go = i_mem_req & ~o_mem_ack & ~tgt_stb;
   // maintenance writes win the cycle, the slave access just waits
   wire wbs_go = i_wbs_cyc & i_wbs_stb & ~o_wbs_ack & ~maint_wr;
   wire [WAW-1:0] tgt_idx = req.addr[WAW+1:2];
   wire [WAW-1:0] cpu_idx = i_mem_addr[WAW+1:2];
   wire [2:0] next_width = (lnk.p_lanes >= OWN_LANES) ? OWN_LANES
                           : LANES_1X;

   // state sequence
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (do_maint | sq_start) begin
               next_state = S_SEND;
            end else if (do_mem) begin
               next_state = S_BUS;
            end
         end
         S_BUS: begin
            if (wb_ack) begin
               next_state = need_rsp ? S_SEND : S_IDLE; // (R6)
            end
         end
         S_SEND: begin
            if (tx_free) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   assign lnk.p2d_ready = rx_ready;
   assign lnk.d2p_pkt = tx_pkt;
   assign lnk.d2p_valid = tx_valid;
   assign lnk.d_lanes = OWN_LANES;

   // control, reply build and transmit register
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= S_IDLE;
         rx_ready <= 1'b0;
         req <= '0;
         rply <= '0;
         tx_pkt <= '0;
         tx_valid <= 1'b0;
      end else begin
         state <= next_state;
         rx_ready <= (next_state == S_IDLE) & ~sq_start;
         if (do_mem) begin
            req <= p;
         end
         if (do_maint) begin // (R2)
            rply <= '{FT_MAINT,
                      (p.ttype == TT_MREAD) ? TT_MREAD_RSP : TT_MWRITE_RSP,
                      ST_DONE, p.src, p.dst, p.tid, p.addr,
                      reg_read(p.addr[7:0])};
         end else if (sq_start) begin
            rply <= sq_pkt;
         end else if ((state == S_BUS) & wb_ack) begin // (R6)
            rply <= '{FT_RESP,
                      tgt_we ? TT_RSP_NODATA : TT_RSP_DATA,
                      ST_DONE, req.src, req.dst, req.tid, req.addr,
                      tgt_we ? 32'h0 : wb_dat};
         end
         if ((state == S_SEND) & tx_free) begin
            tx_valid <= 1'b1;
            tx_pkt <= rply;
         end else if (lnk.d2p_ready) begin
            tx_valid <= 1'b0;
         end
      end
   end

   // soft packet queue, both directions
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sq_pkt <= '0;
         sq_armed <= 1'b0;
         o_sq_busy <= 1'b0;
         o_sq_rx_valid <= 1'b0;
         o_sq_rx_pkt <= '0;
      end else begin
         // loading is refused while a packet waits to go
         if (i_sq_load & ~sq_armed) begin
            sq_pkt <= i_sq_pkt;
         end
         // a send strobe in the start cycle re-arms, the set wins
         if (i_sq_send) begin
            sq_armed <= 1'b1; // (R9)
         end else if (sq_start) begin
            sq_armed <= 1'b0;
         end
         o_sq_busy <= i_sq_send | (sq_armed & ~sq_start);
         if (do_sq_rx) begin
            o_sq_rx_valid <= 1'b1; // (R7)
            o_sq_rx_pkt <= p;
         end else if (i_sq_rx_take) begin
            o_sq_rx_valid <= 1'b0;
         end
      end
   end

   // configuration registers, statistics, slave port, link width
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < CFG_N; i++) begin
            cfg[i] <= CFG_RESET;
         end
         rx_cnt <= 32'h0;
         tx_cnt <= 32'h0;
         err_cnt <= 32'h0;
         o_wbs_ack <= 1'b0;
         o_wbs_dat <= 32'h0;
         o_link_width <= LANES_1X;
      end else begin
         if (maint_wr & (p.addr[7:0] < REG_CFG_END)) begin
            cfg[p.addr[4:2]] <= p.data; // (R2)
         end else if (wbs_go & i_wbs_we & (i_wbs_adr < REG_CFG_END)) begin
            cfg[i_wbs_adr[4:2]] <= i_wbs_dat; // (R10)
         end
         o_wbs_ack <= wbs_go;
         if (wbs_go & ~i_wbs_we) begin
            o_wbs_dat <= reg_read(i_wbs_adr); // (R10)
         end
         if (rx_take) begin
            rx_cnt <= rx_cnt + 32'h1; // (R11)
         end
         if (tx_fire) begin
            tx_cnt <= tx_cnt + 32'h1; // (R11)
         end
         if (do_drop) begin
            err_cnt <= err_cnt + 32'h1; // (R16)
         end
         o_link_width <= next_width; // (R13)
      end
   end

   // test memory, target master first, processor second
   always_ff @(posedge i_core_clk) begin
      if (tgt_stb) begin // (R5)
         if (tgt_we) begin
            mem[tgt_idx] <= req.data;
         end
         wb_dat <= mem[tgt_idx];
      end else if (cpu_go) begin
         if (i_mem_we) begin
            mem[cpu_idx] <= i_mem_wdata;
         end
         o_mem_rdata <= mem[cpu_idx];
      end
   end

   // bus cycle acknowledges
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wb_ack <= 1'b0;
         o_mem_ack <= 1'b0;
      end else begin
         wb_ack <= tgt_stb; // (R4)
         o_mem_ack <= cpu_go;
      end
   end
   // lane rate is LANE_RATE_MBPS, a build constant (R12)
endmodule
`default_nettype wire

/* File: inc/srx_pkg.sv */
`default_nettype none
package srx_pkg;
   // packet format codes
   localparam logic [3:0] FT_NREAD = 4'h2;
   localparam logic [3:0] FT_WRITE = 4'h5;
   localparam logic [3:0] FT_MAINT = 4'h8;
   localparam logic [3:0] FT_RESP = 4'hd;
   // transaction codes within a format
   localparam logic [3:0] TT_NWRITE = 4'h4;
   localparam logic [3:0] TT_NWRITE_R = 4'h5;
   localparam logic [3:0] TT_MREAD = 4'h0;
   localparam logic [3:0] TT_MWRITE = 4'h1;
   localparam logic [3:0] TT_MREAD_RSP = 4'h2;
   localparam logic [3:0] TT_MWRITE_RSP = 4'h3;
   localparam logic [3:0] TT_RSP_NODATA = 4'h0;
   localparam logic [3:0] TT_RSP_DATA = 4'h8;
   // response status codes
   localparam logic [3:0] ST_DONE = 4'h0;
   localparam logic [3:0] ST_ERR = 4'h7;
   // transaction id tag that marks soft packet queue traffic
   localparam logic [1:0] SQ_TAG = 2'h3;
   localparam int TID_TAG_HI = 7;
   localparam int TID_TAG_LO = 6;
   // small transport ids and 34-bit addresses
   localparam int ID_W = 8;
   localparam int ADDR_W = 34;
   localparam logic [1:0] ADDR_HI_ZERO = 2'h0;
   // register slave map, byte offsets
   localparam int CFG_N = 8;
   localparam logic [7:0] REG_CFG_BASE = 8'h00;
   localparam logic [7:0] REG_CFG_END = 8'h20;
   localparam logic [7:0] REG_RX_CNT = 8'h40;
   localparam logic [7:0] REG_TX_CNT = 8'h44;
   localparam logic [7:0] REG_ERR_CNT = 8'h48;
   localparam logic [7:0] REG_LINK = 8'h4c;
   localparam logic [31:0] CFG_RESET = 32'h0;
   // fixed lane rate of this build, in Mbit/s
   localparam logic [15:0] LANE_RATE_MBPS = 16'h09c4;
   localparam int LANES_W = 3;
   localparam logic [2:0] LANES_1X = 3'h1;
   // memory geometry, 64 kB test memory
   localparam int MEM_BYTES = 65536;
   localparam int MEM_AW = 16;

   // one packet travels as a single beat
   typedef struct packed {
      logic [3:0] ftype;
      logic [3:0] ttype;
      logic [3:0] status;
      logic [ID_W-1:0] dst;
      logic [ID_W-1:0] src;
      logic [7:0] tid;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
   } srx_pkt_t;

   // request kinds offered on the partner user port
   typedef enum logic [2:0] {
      K_NREAD = 3'h0,
      K_NWRITE = 3'h1,
      K_NWRITE_R = 3'h2,
      K_MREAD = 3'h3,
      K_MWRITE = 3'h4
   } srx_kind_t;
endpackage
`default_nettype wire

/* File: inc/srx_link_if.sv */
`default_nettype none
interface srx_link_if;
   import srx_pkg::*;
   // partner to device packets
   srx_pkt_t p2d_pkt;
   logic p2d_valid;
   logic p2d_ready;
   // device to partner packets
   srx_pkt_t d2p_pkt;
   logic d2p_valid;
   logic d2p_ready;
   // lanes each end offers
   logic [LANES_W-1:0] p_lanes;
   logic [LANES_W-1:0] d_lanes;

   modport device (
      input p2d_pkt, p2d_valid, d2p_ready, p_lanes,
      output p2d_ready, d2p_pkt, d2p_valid, d_lanes
   );
   modport partner (
      output p2d_pkt, p2d_valid, d2p_ready, p_lanes,
      input p2d_ready, d2p_pkt, d2p_valid, d_lanes
   );
endinterface
`default_nettype wire

/* File: src/srx_partner_end.sv */
`default_nettype none
module srx_partner_end
   import srx_pkg::*;
#(
   parameter logic [2:0] LANES = 3'h1,
   parameter logic [7:0] SRC_ID = 8'h01
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // link
   srx_link_if.partner lnk,
   // request from software
   input wire logic i_req_valid,
   input wire srx_kind_t i_req_kind,
   input wire logic [7:0] i_req_dst,
   input wire logic [31:0] i_req_addr,
   input wire logic [31:0] i_req_data,
   output logic o_req_ready,
   // packets received back
   output logic o_rsp_valid,
   output srx_pkt_t o_rsp_pkt,
   input wire logic i_rsp_take
);
   logic [5:0] seq;
   srx_pkt_t tx_pkt;
   logic tx_valid;
   logic rx_ready;

   // request encoding
   wire req_take = i_req_valid & o_req_ready;
   wire is_maint = (i_req_kind == K_MREAD) | (i_req_kind == K_MWRITE);
   wire [3:0] kind_ft = (i_req_kind == K_NREAD) ? FT_NREAD :
                        is_maint ? FT_MAINT : FT_WRITE;
   wire [3:0] kind_tt = (i_req_kind == K_NWRITE) ? TT_NWRITE :
                        (i_req_kind == K_NWRITE_R) ? TT_NWRITE_R :
                        (i_req_kind == K_MWRITE) ? TT_MWRITE : TT_MREAD;
   wire next_tx_valid = req_take | (tx_valid & ~lnk.p2d_ready);
   wire rx_take = lnk.d2p_valid & rx_ready;
   wire next_rsp_valid = rx_take | (o_rsp_valid & ~i_rsp_take);

   assign lnk.p2d_pkt = tx_pkt;
   assign lnk.p2d_valid = tx_valid;
   assign lnk.d2p_ready = rx_ready;
   assign lnk.p_lanes = LANES;

   // one request in flight on the link, one answer held for software
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         seq <= 6'h0;
         tx_pkt <= '0;
         tx_valid <= 1'b0;
         o_req_ready <= 1'b1;
         rx_ready <= 1'b1;
         o_rsp_valid <= 1'b0;
         o_rsp_pkt <= '0;
      end else begin
         tx_valid <= next_tx_valid;
         o_req_ready <= ~next_tx_valid;
         o_rsp_valid <= next_rsp_valid;
         rx_ready <= ~next_rsp_valid;
         if (rx_take) begin
            o_rsp_pkt <= lnk.d2p_pkt;
         end
         if (req_take) begin
            seq <= seq + 6'h1;
            tx_pkt.ftype <= kind_ft;
            tx_pkt.ttype <= kind_tt;
            tx_pkt.status <= ST_DONE;
            tx_pkt.dst <= i_req_dst; // (R15)
            tx_pkt.src <= SRC_ID; // (R15)
            tx_pkt.tid <= {SQ_TAG, seq}; // (R8)
            tx_pkt.addr <= {ADDR_HI_ZERO, i_req_addr}; // (R14)
            tx_pkt.data <= i_req_data;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/srx_link_sva.sv */
`default_nettype none
module srx_link_sva
   import srx_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // link signals
   input wire srx_pkt_t p2d_pkt,
   input wire logic p2d_valid,
   input wire logic p2d_ready,
   input wire srx_pkt_t d2p_pkt,
   input wire logic d2p_valid,
   input wire logic d2p_ready,
   input wire logic [LANES_W-1:0] p_lanes,
   input wire logic [LANES_W-1:0] d_lanes
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   // decoded acceptance of a partner packet
   wire take = p2d_valid && p2d_ready;
   wire is_rd = p2d_pkt.ftype == FT_NREAD;
   wire is_mt = p2d_pkt.ftype == FT_MAINT;
   wire is_wr = p2d_pkt.ftype == FT_WRITE && p2d_pkt.ttype == TT_NWRITE;
   wire d_rsp = d2p_valid && d2p_pkt.ftype == FT_RESP;

   property p_rd_reply;
      take && is_rd |-> ##[3:4] d_rsp && d2p_pkt.ttype == TT_RSP_DATA;
   endproperty
   a_rd_reply: assert property (p_rd_reply) else $error("no read reply");
   property p_mt_reply;
      take && is_mt |-> ##[1:3] d2p_valid && d2p_pkt.ftype == FT_MAINT;
   endproperty
   a_mt_reply: assert property (p_mt_reply) else $error("no maint reply");
   property p_wr_quiet;
      take && is_wr |=> !d2p_valid [*2];
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("nwrite replied");
   property p_busy;
      take && is_rd |=> !p2d_ready [*2];
   endproperty
   a_busy: assert property (p_busy) else $error("ready during bus cycle");
   property p_tag;
      p2d_valid |-> p2d_pkt.tid[TID_TAG_HI:TID_TAG_LO] == SQ_TAG;
   endproperty
   a_tag: assert property (p_tag) else $error("request tid untagged");
   property p_addr;
      p2d_valid |-> p2d_pkt.addr[ADDR_W-1:32] == ADDR_HI_ZERO;
   endproperty
   a_addr: assert property (p_addr) else $error("address top not zero");
   property p_rsp_ok;
      d_rsp |-> d2p_pkt.status == ST_DONE && d2p_pkt.tid[7:6] == SQ_TAG;
   endproperty
   a_rsp_ok: assert property (p_rsp_ok) else $error("bad response");
   property p_p_hold;
      p2d_valid && !p2d_ready |=> p2d_valid && $stable(p2d_pkt);
   endproperty
   a_p_hold: assert property (p_p_hold) else $error("p2d dropped");
   property p_d_hold;
      d2p_valid && !d2p_ready |=> d2p_valid && $stable(d2p_pkt);
   endproperty
   a_d_hold: assert property (p_d_hold) else $error("d2p dropped");
   // main traffic kinds seen
   c_rd: cover property (take && is_rd);
   c_mt: cover property (take && is_mt);
   c_sq: cover property (d2p_valid && d2p_pkt.ftype == FT_WRITE);
endmodule
`default_nettype wire

/* File: verif/tb_srio_rx_demux_target_memory.sv */
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_fail++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_srio_rx_demux_target_memory
   import srx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 0, i_arst_n = 0;
   int n_fail = 0, checks = 0, cyc = 0;
   logic wb_cs, wb_we, wb_ack, mreq, mwe, m_ack, sq_load, sq_send, sq_busy;
   logic sq_rv, sq_take, rq_valid, rq_ready, rsp_v, rsp_take;
   logic [7:0] wb_adr;
   logic [15:0] m_adr;
   logic [31:0] wb_dat, wb_q, m_wd, m_q, rq_addr, rq_data, rd, c0, c1;
   logic [2:0] lw;
   srx_pkt_t sq_pkt, sq_rp, rsp_p, pk;
   srx_kind_t rq_kind;
   srx_link_if lnk_if ();
   srx_device_end srx_device_end_inst (.i_core_clk, .i_arst_n, .lnk(lnk_if),
      .i_wbs_cyc(wb_cs), .i_wbs_stb(wb_cs), .i_wbs_we(wb_we),
      .i_wbs_adr(wb_adr), .i_wbs_dat(wb_dat), .o_wbs_dat(wb_q),
      .o_wbs_ack(wb_ack), .i_mem_req(mreq), .i_mem_we(mwe),
      .i_mem_addr(m_adr), .i_mem_wdata(m_wd), .o_mem_rdata(m_q),
      .o_mem_ack(m_ack), .i_sq_load(sq_load), .i_sq_pkt(sq_pkt),
      .i_sq_send(sq_send), .o_sq_busy(sq_busy), .o_sq_rx_valid(sq_rv),
      .o_sq_rx_pkt(sq_rp), .i_sq_rx_take(sq_take), .o_link_width(lw));
   srx_partner_end srx_partner_end_inst (.i_core_clk, .i_arst_n,
      .lnk(lnk_if), .i_req_valid(rq_valid), .i_req_kind(rq_kind),
      .i_req_dst(8'h02), .i_req_addr(rq_addr), .i_req_data(rq_data),
      .o_req_ready(rq_ready), .o_rsp_valid(rsp_v), .o_rsp_pkt(rsp_p),
      .i_rsp_take(rsp_take));
   srx_link_sva srx_link_sva_inst (.i_core_clk, .i_arst_n,
      .p2d_pkt(lnk_if.p2d_pkt), .p2d_valid(lnk_if.p2d_valid),
      .p2d_ready(lnk_if.p2d_ready), .d2p_pkt(lnk_if.d2p_pkt),
      .d2p_valid(lnk_if.d2p_valid), .d2p_ready(lnk_if.d2p_ready),
      .p_lanes(lnk_if.p_lanes), .d_lanes(lnk_if.d_lanes));
   // 200 MHz core clock
   always #2.5 i_core_clk = ~i_core_clk;
   // hang guard, tests need well under a thousand cycles
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out;
      end
   end
   task automatic step;
      @(posedge i_core_clk);
      #1;
   endtask
   // register slave access, held through the edge that sees ack
   task automatic cpu_register_slave_port(input logic we, input logic [7:0] a);
      int n = 0;
      wb_we = we;
      wb_adr = a;
      wb_cs = 1;
      do begin step; n++; end while (wb_ack !== 1 && n < 50);
      if (wb_ack !== 1) n_fail++;
      rd = wb_q;
      step;
      wb_cs = 0;
      step;
   endtask
   // cpu test memory word access
   task automatic mem(input logic we, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      mwe = we;
      m_adr = a;
      m_wd = d;
      mreq = 1;
      do begin step; n++; end while (m_ack !== 1 && n < 50);
      if (m_ack !== 1) n_fail++;
      rd = m_q;
      step;
      mreq = 0;
      step;
   endtask
   // partner request, raised only once ready stands, so one edge takes it
   task automatic preq(input srx_kind_t k, input logic [31:0] a, d);
      int n = 0;
      while (rq_ready !== 1 && n < 50) begin step; n++; end
      if (rq_ready !== 1) n_fail++;
      rq_kind = k;
      rq_addr = a;
      rq_data = d;
      rq_valid = 1;
      step;
      rq_valid = 0;
      step;
   endtask
   // collect one packet at the partner
   task automatic prsp;
      int n = 0;
      do begin step; n++; end while (rsp_v !== 1 && n < 50);
      if (rsp_v !== 1) n_fail++;
      pk = rsp_p;
      rsp_take = 1;
      step;
      rsp_take = 0;
   endtask
   task automatic t_mem_path;
      preq(K_NWRITE, 32'h10, 32'hcafe0001);
      mem(0, 16'h10, 32'h0);
      `CHK("mem_nwrite", 32'hcafe0001, rd)
      mem(1, 16'h20, 32'h5a5a0002);
      preq(K_NREAD, 32'h20, 32'h0);
      prsp;
      `CHK("rd_ftype", FT_RESP, pk.ftype)
      `CHK("rd_ttype", TT_RSP_DATA, pk.ttype)
      `CHK("rd_data", 32'h5a5a0002, pk.data)
      `CHK("rd_tag", SQ_TAG, pk.tid[7:6])
      preq(K_NWRITE_R, 32'h24, 32'h00000077);
      prsp;
      `CHK("wr_r_ttype", TT_RSP_NODATA, pk.ttype)
      mem(0, 16'h24, 32'h0);
      `CHK("mem_nwrite_r", 32'h00000077, rd)
      $display("test mem_path done");
   endtask
   task automatic t_maint;
      preq(K_MWRITE, 32'h04, 32'h1234abcd);
      prsp;
      `CHK("mw_ttype", TT_MWRITE_RSP, pk.ttype)
      preq(K_MREAD, 32'h04, 32'h0);
      prsp;
      `CHK("mr_ttype", TT_MREAD_RSP, pk.ttype)
      `CHK("mr_data", 32'h1234abcd, pk.data)
      cpu_register_slave_port(0, 8'h04);
      `CHK("cfg_rd", 32'h1234abcd, rd)
      cpu_register_slave_port(0, 8'h80);
      `CHK("unmapped", 32'h0, rd)
      $display("test maint done");
   endtask
   task automatic t_link;
      cpu_register_slave_port(0, REG_LINK);
      `CHK("link_reg", {LANE_RATE_MBPS, 13'h0, LANES_1X}, rd)
      `CHK("width", LANES_1X, lw)
      $display("test link done");
   endtask
   task automatic t_counts;
      cpu_register_slave_port(0, REG_TX_CNT);
      c0 = rd;
      cpu_register_slave_port(0, REG_RX_CNT);
      c1 = rd;
      // a complete packet is loaded before send is armed
      sq_pkt = '{FT_WRITE, TT_NWRITE, ST_DONE, 8'h01, 8'h02, 8'hc5,
         {2'h0, 32'h40}, 32'h600d0003};
      sq_load = 1;
      step;
      sq_load = 0;
      sq_send = 1;
      step;
      sq_send = 0;
      `CHK("sq_busy", 1'b1, sq_busy)
      prsp;
      `CHK("sq_idle", 1'b0, sq_busy)
      `CHK("sq_data", 32'h600d0003, pk.data)
      `CHK("sq_ttype", TT_NWRITE, pk.ttype)
      cpu_register_slave_port(0, REG_TX_CNT);
      `CHK("tx_cnt", c0 + 32'h1, rd)
      preq(K_NWRITE, 32'h30, 32'h1);
      cpu_register_slave_port(0, REG_RX_CNT);
      `CHK("rx_cnt", c1 + 32'h1, rd)
      // an undecoded write code is dropped, counted, never answered
      preq(srx_kind_t'(3'h5), 32'h50, 32'h0);
      cpu_register_slave_port(0, REG_ERR_CNT);
      `CHK("err_cnt", 32'h1, rd)
      `CHK("drop_quiet", 1'b0, rsp_v)
      `CHK("sq_rx_none", 1'b0, sq_rv)
      $display("test counts done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {wb_cs, wb_we, mreq, mwe, sq_load, sq_send, sq_take} = '0;
      {rq_valid, rsp_take, wb_adr, m_adr, wb_dat, m_wd} = '0;
      {rq_addr, rq_data, sq_pkt} = '0;
      rq_kind = K_NREAD;
      repeat (16) @(posedge i_core_clk);
      #1 i_arst_n = 1;
      t_mem_path;
      t_maint;
      t_link;
      t_counts;
      close_out;
   end
endmodule
`default_nettype wire
